// file: rtl/port_pin_drive_config.sv
// Seven-pin port with per-pin drive and termination select over AXI4-Lite
//
// Function
// - Seven pins, code bits split over two registers
// - Every pin obeys only its own bit pair
// - Low select register first, high one next
// - Low register takes byte or 16-bit access
// - High register alone takes byte access only
// - Direction zero output meanings, one input meanings
// - Output codes: hi-z, P-drain, N-drain, push-pull
// - Codes reset to zero, high impedance
// - Input codes: hi-z, pull-down, pull-up
// - Output pins drive their level register bit
// - Reset gives hi-z output, direction output
`timescale 1ns/1ps
module port_pin_drive_config (
	input wire logic aclk,
	input wire logic aresetn,
	// Write address channel
	input wire logic awvalid,
	output logic awready,
	input wire logic [pin_drive_pkg::addr_width-1:0] awaddr,
	input wire logic [2:0] awprot,
	// Write data channel
	input wire logic wvalid,
	output logic wready,
	input wire logic [pin_drive_pkg::data_width-1:0] wdata,
	input wire logic [pin_drive_pkg::strb_width-1:0] wstrb,
	// Write response channel
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// Read address channel
	input wire logic arvalid,
	output logic arready,
	input wire logic [pin_drive_pkg::addr_width-1:0] araddr,
	input wire logic [2:0] arprot,
	// Read data channel
	output logic rvalid,
	input wire logic rready,
	output logic [pin_drive_pkg::data_width-1:0] rdata,
	output logic [1:0] rresp,
	// Pad side
	input wire logic [pin_drive_pkg::pin_count-1:0] pad_in,
	output logic [pin_drive_pkg::pin_count-1:0] pad_out,
	output logic [pin_drive_pkg::pin_count-1:0] pad_oe,
	output logic [pin_drive_pkg::pin_count-1:0] pull_up_en,
	output logic [pin_drive_pkg::pin_count-1:0] pull_down_en
);
	import pin_drive_pkg::*;

	// Register state
	logic [6:0] pin_level_register_q;
	logic [6:0] pin_level_register_d;
	logic [6:0] pin_direction_register_q;
	logic [6:0] pin_direction_register_d;
	logic [6:0] pin_drive_select_low_q;
	logic [6:0] pin_drive_select_low_d;
	logic [6:0] pin_drive_select_high_q;
	logic [6:0] pin_drive_select_high_d;

	// Pad input synchroniser
	logic [6:0] pad_meta_q;
	logic [6:0] pad_sync_q;

	// Write channel holding
	chan_state_type wr_state_q;
	chan_state_type wr_state_d;
	logic aw_have_q;
	logic aw_have_d;
	logic w_have_q;
	logic w_have_d;
	logic [17:0] aw_index_q;
	logic [17:0] aw_index_d;
	logic [31:0] w_data_q;
	logic [31:0] w_data_d;
	logic [3:0] w_strb_q;
	logic [3:0] w_strb_d;
	logic [1:0] bresp_q;
	logic [1:0] bresp_d;

	// Read channel holding
	chan_state_type rd_state_q;
	chan_state_type rd_state_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [1:0] rresp_q;
	logic [1:0] rresp_d;

	// Handshake and decode wires
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic wr_commit;
	logic wr_hit_level;
	logic wr_hit_dir;
	logic wr_hit_low;
	logic wr_hit_high;
	logic wr_mapped;
	logic [17:0] ar_index;
	logic rd_hit_level;
	logic rd_hit_dir;
	logic rd_hit_low;
	logic rd_hit_high;
	logic rd_mapped;
	logic [6:0] lane0_bits;
	logic [6:0] lane1_bits;
	logic lane0_en;
	logic lane1_en;
	logic [6:0] level_view;

	// Each half of a write parks in its own slot, so address and data
	// may arrive in either order; a slot frees only when the pair commits
	// Ready while the holding slot is free and no answer is pending
	assign awready = ~aw_have_q & (wr_state_q == chan_idle);
	assign wready = ~w_have_q & (wr_state_q == chan_idle);
	assign arready = (rd_state_q == chan_idle);
	assign aw_take = awvalid & awready;
	assign w_take = wvalid & wready;
	assign ar_take = arvalid & arready;

	// Committing from the held copies costs a cycle of latency but keeps
	// the address compare off the bus pins, which eases timing
	// A write commits the cycle after both halves are held
	assign wr_commit = aw_have_q & w_have_q & (wr_state_q == chan_idle);

	// Write decode on the held index
	assign wr_hit_level = (aw_index_q == level_index);
	assign wr_hit_dir = (aw_index_q == direction_index);
	assign wr_hit_low = (aw_index_q == select_low_index);
	assign wr_hit_high = (aw_index_q == select_high_index);
	assign wr_mapped = wr_hit_level | wr_hit_dir | wr_hit_low | wr_hit_high;

	// Only lanes 0 and 1 can reach storage; lanes 2 and 3 have no register
	// behind them at any index, so their strobes are ignored, not refused
	// Byte lanes; bit 7 of each lane is dropped, so it never stores
	assign lane0_bits = w_data_q[field_msb:field_lsb];
	assign lane1_bits = w_data_q[word_high_msb:word_high_lsb];
	assign lane0_en = wr_commit & w_strb_q[0];
	assign lane1_en = wr_commit & w_strb_q[1];

	// Kept on purpose: software may preload the level of an input pin
	// before turning it round, so the pin comes up at the intended level
	// with no glitch when it becomes an output
	// Level register stores writes whatever the pin direction
	assign pin_level_register_d =
		(lane0_en & wr_hit_level) ? lane0_bits : pin_level_register_q;

	// Direction register
	assign pin_direction_register_d =
		(lane0_en & wr_hit_dir) ? lane0_bits : pin_direction_register_q;

	// Low code bits: byte lane 0 at the low select index
	assign pin_drive_select_low_d =
		(lane0_en & wr_hit_low) ? lane0_bits
		: pin_drive_select_low_q;

	// A 16-bit write at the low index updates both code halves at one
	// edge, so a pin never passes through a mixed code; a byte write at
	// the high index leaves the low code bits untouched
	// High code bits: lane 1 of a 16-bit access at the low index, or
	// lane 0 at its own index; higher lanes there are ignored
	assign pin_drive_select_high_d =
		(lane1_en & wr_hit_low) ? lane1_bits
		: (lane0_en & wr_hit_high) ? lane0_bits
		: pin_drive_select_high_q;

	// The response is the only record of a refused write; no error flag
	// is kept, so software has to look at it on every access
	// Write response code; unmapped writes store nothing
	assign bresp_d = wr_commit ? (wr_mapped ? resp_okay : resp_slverr)
		: bresp_q;

	// Write channel next state
	assign aw_index_d = aw_take ? awaddr[19:2] : aw_index_q;
	assign w_data_d = w_take ? wdata : w_data_q;
	assign w_strb_d = w_take ? wstrb : w_strb_q;
	assign aw_have_d = aw_take | (aw_have_q & ~wr_commit);
	assign w_have_d = w_take | (w_have_q & ~wr_commit);

	// Write state: idle until commit, then answer until bready
	always_comb begin
		wr_state_d = wr_state_q;
		case (wr_state_q)
			chan_idle: begin
				if (wr_commit) begin
					wr_state_d = chan_resp;
				end
			end
			chan_resp: begin
				if (bready) begin
					wr_state_d = chan_idle;
				end
			end
			default: begin
				wr_state_d = chan_idle;
			end
		endcase
	end

	// Read data are captured in the take cycle itself, so the address
	// only has to stand while arvalid does
	// Read decode straight from the address bus
	assign ar_index = araddr[19:2];
	assign rd_hit_level = (ar_index == level_index);
	assign rd_hit_dir = (ar_index == direction_index);
	assign rd_hit_low = (ar_index == select_low_index);
	assign rd_hit_high = (ar_index == select_high_index);
	assign rd_mapped = rd_hit_level | rd_hit_dir | rd_hit_low | rd_hit_high;

	// The synchroniser adds two cycles, so an input pin reads back the
	// pad as it stood about two clocks before the read was taken
	// Input pins read their synchronised pad, output pins the stored bit
	assign level_view = (pin_direction_register_q & pad_sync_q) |
		(~pin_direction_register_q & pin_level_register_q);

	// Read data: low index shows the 16-bit pair, bit 7s read zero
	always_comb begin
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (ar_take) begin
			rdata_d = 32'h0000_0000;
			rresp_d = rd_mapped ? resp_okay : resp_slverr;
			if (rd_hit_level) begin
				rdata_d[field_msb:field_lsb] = level_view;
			end
			if (rd_hit_dir) begin
				rdata_d[field_msb:field_lsb] = pin_direction_register_q;
			end
			if (rd_hit_low) begin
				rdata_d[field_msb:field_lsb] = pin_drive_select_low_q;
				rdata_d[word_high_msb:word_high_lsb] =
					pin_drive_select_high_q;
			end
			if (rd_hit_high) begin
				rdata_d[field_msb:field_lsb] = pin_drive_select_high_q;
			end
		end
	end

	// Read state: answer until rready
	always_comb begin
		rd_state_d = rd_state_q;
		case (rd_state_q)
			chan_idle: begin
				if (ar_take) begin
					rd_state_d = chan_resp;
				end
			end
			chan_resp: begin
				if (rready) begin
					rd_state_d = chan_idle;
				end
			end
			default: begin
				rd_state_d = chan_idle;
			end
		endcase
	end

	// Bus outputs
	assign bvalid = (wr_state_q == chan_resp);
	assign bresp = bresp_q;
	assign rvalid = (rd_state_q == chan_resp);
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// Direction and codes clear together, so nothing is driven onto the
	// board before software has configured the port
	// Configuration registers; reset leaves every pin hi-z output
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_level_register_q <= level_reset;
			pin_direction_register_q <= direction_reset;
			pin_drive_select_low_q <= select_low_reset;
			pin_drive_select_high_q <= select_high_reset;
		end else begin
			pin_level_register_q <= pin_level_register_d;
			pin_direction_register_q <= pin_direction_register_d;
			pin_drive_select_low_q <= pin_drive_select_low_d;
			pin_drive_select_high_q <= pin_drive_select_high_d;
		end
	end

	// Two-stage synchroniser; only the second stage is read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pad_meta_q <= 7'h00;
			pad_sync_q <= 7'h00;
		end else begin
			pad_meta_q <= pad_in;
			pad_sync_q <= pad_meta_q;
		end
	end

	// Write channel holding registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_q <= chan_idle;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_index_q <= 18'h00000;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bresp_q <= resp_okay;
		end else begin
			wr_state_q <= wr_state_d;
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			aw_index_q <= aw_index_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			bresp_q <= bresp_d;
		end
	end

	// Read channel registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_q <= chan_idle;
			rdata_q <= 32'h0000_0000;
			rresp_q <= resp_okay;
		end else begin
			rd_state_q <= rd_state_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// Registered pad controls make a code change take effect one edge
	// after the write lands, on all drive and pull outputs at once
	// One cell per pin, each fed its own bit pair only
	generate
		for (genvar i = 0; i < pin_count; i++) begin : g_pin
			pin_drive_cell u_cell (
				.aclk(aclk),
				.aresetn(aresetn),
				.dir(pin_direction_register_q[i]),
				.code({pin_drive_select_high_q[i],
					pin_drive_select_low_q[i]}),
				.level(pin_level_register_q[i]),
				.pad_out(pad_out[i]),
				.pad_oe(pad_oe[i]),
				.pull_up_en(pull_up_en[i]),
				.pull_down_en(pull_down_en[i])
			);
		end
	endgenerate

endmodule // port_pin_drive_config

// file: rtl/pin_drive_pkg.sv
// Constants shared by the pin drive configuration block
package pin_drive_pkg;

	// Port geometry
	localparam int unsigned pin_count = 7;
	localparam int unsigned code_width = 2;
	localparam int unsigned reg_width = 8;

	// AXI4-Lite geometry
	localparam int unsigned addr_width = 20;
	localparam int unsigned data_width = 32;
	localparam int unsigned strb_width = 4;

	// Register indices; byte address is four times the index
	localparam logic [17:0] level_index = 18'h0f218;
	localparam logic [17:0] direction_index = 18'h0f219;
	localparam logic [17:0] select_low_index = 18'h0f21a;
	localparam logic [17:0] select_high_index = 18'h0f21b;

	// Values after reset
	localparam logic [6:0] level_reset = 7'h00;
	localparam logic [6:0] direction_reset = 7'h00;
	localparam logic [6:0] select_low_reset = 7'h00;
	localparam logic [6:0] select_high_reset = 7'h00;

	// Field positions
	localparam int unsigned field_lsb = 0;
	localparam int unsigned field_msb = 6;
	localparam int unsigned word_high_lsb = 8;
	localparam int unsigned word_high_msb = 14;

	// Direction bit meaning
	localparam logic dir_output = 1'b0;
	localparam logic dir_input = 1'b1;

	// Drive codes in output mode
	localparam logic [1:0] out_hiz = 2'h0;
	localparam logic [1:0] out_pch_open_drain = 2'h1;
	localparam logic [1:0] out_nch_open_drain = 2'h2;
	localparam logic [1:0] out_push_pull = 2'h3;

	// Termination codes in input mode
	localparam logic [1:0] in_hiz = 2'h0;
	localparam logic [1:0] in_pull_down = 2'h1;
	localparam logic [1:0] in_pull_up = 2'h2;

	// AXI responses
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

	// Handshake states, one-hot
	typedef enum logic [1:0] {
		chan_idle = 2'b01,
		chan_resp = 2'b10
	} chan_state_type;

endpackage

// file: rtl/pin_drive_cell.sv
// One port pin: turns direction, code and level into pad controls
`timescale 1ns/1ps
module pin_drive_cell (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic dir,
	input wire logic [1:0] code,
	input wire logic level,
	output logic pad_out,
	output logic pad_oe,
	output logic pull_up_en,
	output logic pull_down_en
);
	import pin_drive_pkg::*;

	logic out_mode;
	logic drive_d;
	logic oe_d;
	logic pu_d;
	logic pd_d;

	// Decode; only this pin's own code and bits feed it
	assign out_mode = (dir == dir_output);
	assign drive_d = out_mode & level;
	assign oe_d = out_mode & ((code == out_push_pull) |
		((code == out_pch_open_drain) & level) |
		((code == out_nch_open_drain) & ~level));
	assign pu_d = ~out_mode & (code == in_pull_up);
	assign pd_d = ~out_mode & (code == in_pull_down);

	// Registered pad controls, released at reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pad_out <= 1'b0;
			pad_oe <= 1'b0;
			pull_up_en <= 1'b0;
			pull_down_en <= 1'b0;
		end else begin
			pad_out <= drive_d;
			pad_oe <= oe_d;
			pull_up_en <= pu_d;
			pull_down_en <= pd_d;
		end
	end
endmodule // pin_drive_cell

// file: verification/pin_drive_monitor.sv
// Protocol and pad checks for the pin drive block
`timescale 1ns/1ps
module pin_drive_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [6:0] pad_oe,
	input wire logic [6:0] pull_up_en,
	input wire logic [6:0] pull_down_en
);
	import pin_drive_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Handshake timing and holding of answers
	// Both halves taken at one edge, commit at the next, answer after that
	chk_write_answer: assert property (awvalid && awready && wvalid && wready
		|-> ##2 bvalid) else $error("write answer late");
	chk_bresp_held: assert property (bvalid && !bready |=> bvalid
		&& $stable(bresp)) else $error("write answer dropped");
	chk_write_blocked: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while answering");
	chk_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	chk_rdata_held: assert property (rvalid && !rready |=> rvalid
		&& $stable(rdata)) else $error("read answer dropped");
	// Bits 31:15 and bit 7 of every read answer are zero
	chk_reserved_zero: assert property (rvalid |-> rdata[31:15] == '0
		&& rdata[7] == 1'h0) else $error("reserved bit set");
	// A pin never pulls both ways, and never drives and pulls at once
	chk_pull_single: assert property ((pull_up_en & pull_down_en) == '0)
		else $error("both pulls on");
	chk_oe_no_pull: assert property ((pad_oe & (pull_up_en | pull_down_en))
		== '0) else $error("drive with pull");
	chk_reset_hiz: assert property ($rose(aresetn) |-> pad_oe == '0
		&& pull_up_en == '0 && pull_down_en == '0) else $error("pads live");
	cov_write: cover property (bvalid && bready);
	cov_read: cover property (rvalid && rready);
	cov_pull: cover property (pull_up_en != '0 && pull_down_en != '0);
endmodule // pin_drive_monitor

bind port_pin_drive_config pin_drive_monitor mon (
	.aclk(aclk),
	.aresetn(aresetn),
	.awvalid(awvalid),
	.awready(awready),
	.wvalid(wvalid),
	.wready(wready),
	.bvalid(bvalid),
	.bready(bready),
	.bresp(bresp),
	.arvalid(arvalid),
	.arready(arready),
	.rvalid(rvalid),
	.rready(rready),
	.rdata(rdata),
	.pad_oe(pad_oe),
	.pull_up_en(pull_up_en),
	.pull_down_en(pull_down_en)
);

// file: verification/pin_world.sv
// Circuitry outside the port pins: drivers, resistors, floating lines
`timescale 1ns/1ps
module pin_world (
	input wire logic aclk,
	input wire logic [6:0] pad_out,
	input wire logic [6:0] pad_oe,
	input wire logic [6:0] pull_up_en,
	input wire logic [6:0] pull_down_en,
	input wire logic [6:0] ext_val,
	input wire logic [6:0] ext_en,
	output logic [6:0] pad_in
);
	logic [6:0] last_q = 7'h00;
	// Floating pins flip every cycle so no reading can lean on luck
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			if (pad_oe[i])
				pad_in[i] = pad_out[i];
			else if (ext_en[i])
				pad_in[i] = ext_val[i];
			else if (pull_up_en[i])
				pad_in[i] = 1'h1;
			else if (pull_down_en[i])
				pad_in[i] = 1'h0;
			else
				pad_in[i] = ~last_q[i];
		end
	end
	// Known start so a floating line toggles instead of staying unknown
	always @(posedge aclk) begin
		last_q <= pad_in;
	end
endmodule // pin_world

// file: verification/port_pin_drive_config_test.sv
// Self-checking bench for the pin drive configuration block
`timescale 1ns/1ps
module port_pin_drive_config_test;
	import pin_drive_pkg::*;
	localparam logic [19:0] a_lvl = {level_index, 2'h0};
	localparam logic [19:0] a_dir = {direction_index, 2'h0};
	localparam logic [19:0] a_lo = {select_low_index, 2'h0};
	localparam logic [19:0] a_hi = {select_high_index, 2'h0};
	localparam logic [19:0] a_bad = 20'h00100;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic awvalid = 1'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [19:0] awaddr = 20'h0;
	logic [19:0] araddr = 20'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [3:0] wstrb = 4'h0;
	logic [1:0] bresp, rresp;
	logic [6:0] pad_in, pad_out, pad_oe, pull_up_en, pull_down_en;
	logic [6:0] ext_val = 7'h05;
	logic [6:0] ext_en = 7'h1f;
	int n_errors = 0;
	int num_checks = 0;

	port_pin_drive_config uut (
		.aclk(aclk),
		.aresetn(aresetn),
		.awvalid(awvalid),
		.awready(awready),
		.awaddr(awaddr),
		.awprot(3'h0),
		.wvalid(wvalid),
		.wready(wready),
		.wdata(wdata),
		.wstrb(wstrb),
		.bvalid(bvalid),
		.bready(bready),
		.bresp(bresp),
		.arvalid(arvalid),
		.arready(arready),
		.araddr(araddr),
		.arprot(3'h0),
		.rvalid(rvalid),
		.rready(rready),
		.rdata(rdata),
		.rresp(rresp),
		.pad_in(pad_in),
		.pad_out(pad_out),
		.pad_oe(pad_oe),
		.pull_up_en(pull_up_en),
		.pull_down_en(pull_down_en)
	);
	pin_world world (
		.aclk(aclk),
		.pad_out(pad_out),
		.pad_oe(pad_oe),
		.pull_up_en(pull_up_en),
		.pull_down_en(pull_down_en),
		.ext_val(ext_val),
		.ext_en(ext_en),
		.pad_in(pad_in)
	);

	initial begin
		forever #10 aclk = ~aclk;
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task chk7(input string nm, input logic [6:0] e, input logic [6:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	// Readies are combinational, so they are sampled mid-cycle where settled
	task wr(input logic [19:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic ta, tw;
		ta = 1'h0;
		tw = 1'h0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		while (!ta || !tw) begin
			@(negedge aclk);
			ta = ta | awready;
			tw = tw | wready;
			@(posedge aclk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
		end
		// Raised at the take edge, never where the last call lowered it
		bready <= 1'h1;
		do @(negedge aclk); while (!bvalid);
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		@(posedge aclk);
		bready <= 1'h0;
	endtask
	task rd(input logic [19:0] a, input logic [31:0] e, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'h1;
		do @(negedge aclk); while (!arready);
		@(posedge aclk);
		arvalid <= 1'h0;
		rready <= 1'h1;
		do @(negedge aclk); while (!rvalid);
		chk("rdata", e, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		@(posedge aclk);
		rready <= 1'h0;
	endtask

	// Pad controls expected from direction, code bit pairs and levels
	task pins(input logic [6:0] dir, input logic [6:0] lo,
		input logic [6:0] hi, input logic [6:0] lv);
		logic [6:0] oe, pu, pd;
		logic [1:0] c;
		// Pad controls launch at an edge; look at them mid-cycle
		@(negedge aclk);
		for (int i = 0; i < 7; i++) begin
			c = {hi[i], lo[i]};
			oe[i] = !dir[i] && (c == out_push_pull
				|| (c == out_pch_open_drain && lv[i])
				|| (c == out_nch_open_drain && !lv[i]));
			pu[i] = dir[i] && c == in_pull_up;
			pd[i] = dir[i] && c == in_pull_down;
		end
		chk7("pad_oe", oe, pad_oe);
		chk7("pull_up_en", pu, pull_up_en);
		chk7("pull_down_en", pd, pull_down_en);
		chk7("pad_out", lv & oe, pad_out & pad_oe);
		@(posedge aclk);
	endtask

	task t_reset;
		rd(a_lo, 32'h0, resp_okay);
		rd(a_hi, 32'h0, resp_okay);
		rd(a_dir, 32'h0, resp_okay);
		pins(7'h00, 7'h00, 7'h00, 7'h00);
	endtask
	// Bit 7 of each stored lane is set in the writes and must not stick
	task t_regs;
		wr(a_lo, 32'hffff_b3d5, 4'h3, resp_okay);
		rd(a_lo, 32'h0000_3355, resp_okay);
		rd(a_hi, 32'h0000_0033, resp_okay);
		wr(a_hi, 32'h0000_11cc, 4'h3, resp_okay);
		rd(a_hi, 32'h0000_004c, resp_okay);
		wr(a_lo, 32'h0000_7faa, 4'h1, resp_okay);
		rd(a_lo, 32'h0000_4c2a, resp_okay);
	endtask
	task t_bad;
		wr(a_bad, 32'hffff_ffff, 4'hf, resp_slverr);
		rd(a_bad, 32'h0, resp_slverr);
		rd(a_lo, 32'h0000_4c2a, resp_okay);
	endtask
	// Pins 0..6 carry codes 0,1,2,3,0,1,2 so every code meets both levels
	task t_pins;
		wr(a_lvl, 32'h7f, 4'h1, resp_okay);
		pins(7'h00, 7'h2a, 7'h4c, 7'h7f);
		wr(a_lvl, 32'h00, 4'h1, resp_okay);
		pins(7'h00, 7'h2a, 7'h4c, 7'h00);
		wr(a_dir, 32'h7f, 4'h1, resp_okay);
		pins(7'h7f, 7'h2a, 7'h4c, 7'h00);
		repeat (4) @(posedge aclk);
		rd(a_lvl, 32'h45, resp_okay);
	endtask

	task final_report;
		if (n_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		#200000;
		n_errors++;
		final_report();
	end

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_reset();
		t_regs();
		t_bad();
		t_pins();
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_reset();
		final_report();
	end
endmodule // port_pin_drive_config_test
